// ==== src/alu_rotate_subtract.sv ====
// Combinational rotate-right and subtract-with-borrow unit with flag results
`timescale 1ns/1ps
`default_nettype none
module alu_rotate_subtract
   import rr_sbc_pkg::*;
(
   // Operation and operands
   input  wire alu_op_t    op,
   input  wire logic [7:0] accIn,
   input  wire logic [7:0] memIn,
   input  wire logic [5:0] flagsIn,
   // Results
   output logic [7:0]      result,
   output logic            toAcc,
   output logic            toMem,
   output logic [5:0]      nextFlags,
   output logic [5:0]      flagMask
);

   logic [8:0] diff;
   logic [4:0] lowDiff;
   logic       borrowIn;
   logic       overflow;

   // Borrow is the inverted carry
   assign borrowIn = ~flagsIn[FLAG_C];
   assign diff     = {1'b0, accIn} - {1'b0, memIn} - {8'h00, borrowIn};
   assign lowDiff  = {1'b0, accIn[3:0]} - {1'b0, memIn[3:0]} - {4'h0, borrowIn};
   assign overflow = (accIn[7] ^ memIn[7]) & (accIn[7] ^ diff[7]);

   // Result selection and flag updates per operation
   always_comb begin
      result    = 8'h00;
      toAcc     = 1'b0;
      toMem     = 1'b0;
      nextFlags = flagsIn;
      flagMask  = 6'h00;
      unique case (op)
         OP_ROTATE_RIGHT_TO_ACCUMULATOR: begin
            result = {memIn[0], memIn[7:1]};
            toAcc  = 1'b1;
         end
         OP_ROTATE_RIGHT_CARRY_IN_PLACE: begin
            result            = {flagsIn[FLAG_C], memIn[7:1]};
            toMem             = 1'b1;
            nextFlags[FLAG_C] = memIn[0];
            flagMask[FLAG_C]  = 1'b1;
         end
         OP_ROTATE_RIGHT_CARRY_TO_ACCUMULATOR: begin
            result            = {flagsIn[FLAG_C], memIn[7:1]};
            toAcc             = 1'b1;
            nextFlags[FLAG_C] = memIn[0];
            flagMask[FLAG_C]  = 1'b1;
         end
         OP_SUBTRACT_WITH_BORROW: begin
            result             = diff[7:0];
            toAcc              = 1'b1;
            nextFlags[FLAG_C]  = ~diff[8];
            nextFlags[FLAG_AC] = ~lowDiff[4];
            nextFlags[FLAG_Z]  = (diff[7:0] == 8'h00);
            nextFlags[FLAG_OV] = overflow;
            nextFlags[FLAG_SC] = overflow ^ diff[7];
            // Chained zero only stays set while every byte of a chain is zero
            nextFlags[FLAG_CZ] = (diff[7:0] == 8'h00) & flagsIn[FLAG_CZ];
            flagMask           = 6'h3f;
         end
      endcase
   end

endmodule // alu_rotate_subtract
`default_nettype wire

// ==== src/data_byte_store.sv ====
// Small data memory: one write port, one registered read port
`timescale 1ns/1ps
`default_nettype none
module data_byte_store #(
   parameter int WIDTH = 8,
   parameter int DEPTH = 16,
   parameter int AW    = 4
) (
   // Clock
   input  wire logic             clk,
   // Write port
   input  wire logic             writeEnable,
   input  wire logic [AW-1:0]    writeIndex,
   input  wire logic [WIDTH-1:0] writeData,
   // Read port
   input  wire logic [AW-1:0]    readIndex,
   output var  logic [WIDTH-1:0] readData
);

   logic [WIDTH-1:0] cells [DEPTH];

   // Read is registered; a same-cycle write shows on the next read only
   always_ff @(posedge clk) begin
      if (writeEnable) begin
         cells[writeIndex] <= writeData;
      end
      readData <= cells[readIndex];
   end

endmodule // data_byte_store
`default_nettype wire

// ==== src/rotate_right_and_subtract_carry.sv ====
// Rotate-right / subtract-with-borrow datapath with an AHB-Lite register slave
`timescale 1ns/1ps
`default_nettype none
module rotate_right_and_subtract_carry
   import rr_sbc_pkg::*;
(
   // Clock and reset
   input  wire logic        sys_clk,
   input  wire logic        rst_n,
   // AHB-Lite address phase
   input  wire logic        hsel,
   input  wire logic [31:0] haddr,
   input  wire logic [1:0]  htrans,
   input  wire logic        hwrite,
   input  wire logic [2:0]  hsize,
   input  wire logic        hready,
   // AHB-Lite data phase
   input  wire logic [31:0] hwdata,
   output logic [31:0]      hrdata,
   output logic             hreadyout,
   output logic             hresp
);

   // Bus sequencing states
   typedef enum logic [1:0] {
      BUS_IDLE  = 2'b00,
      BUS_READ1 = 2'b01,
      BUS_READ2 = 2'b10,
      BUS_CMD   = 2'b11
   } bus_state_t;

   // Operation engine states
   typedef enum logic [1:0] {
      ENG_IDLE  = 2'b00,
      ENG_FETCH = 2'b01,
      ENG_EXEC  = 2'b10
   } eng_state_t;

   bus_state_t                 busState;
   eng_state_t                 engState;

   // Captured address phase
   logic                       accept;
   logic                       dpValid;
   logic                       dpWrite;
   logic                       dpSizeOk;
   logic [7:0]                 dpAddr;

   // Architectural state
   logic [7:0]                 acc;
   logic [5:0]                 flags;
   alu_op_t                    cmdOp;
   logic [MEM_INDEX_WIDTH-1:0] cmdIndex;

   // Decodes of the captured address
   logic                       selAcc;
   logic                       selStatus;
   logic                       selCmd;
   logic                       selMem;
   logic                       busWrite;
   logic                       startCmd;

   // Address-phase kinds
   logic                       takeRead;
   logic                       takeCmd;

   // Memory and datapath wiring
   logic                       memWe;
   logic [MEM_INDEX_WIDTH-1:0] memWIndex;
   logic [7:0]                 memWData;
   logic [MEM_INDEX_WIDTH-1:0] memRIndex;
   logic [7:0]                 memRData;
   logic [7:0]                 aluResult;
   logic                       aluToAcc;
   logic                       aluToMem;
   logic [5:0]                 aluFlags;
   logic [5:0]                 aluMask;
   logic                       engCommit;
   logic [31:0]                readWord;

   // Any active transfer with hsel and hready is taken, whatever its size
   assign accept = hsel & htrans[1] & hready;

   // Kinds of accepted address phase; a byte-sized command write is ignored
   assign takeRead = accept & ~hwrite;
   assign takeCmd  = accept & hwrite & (hsize == HSIZE_WORD) & (haddr[7:0] == CMD_OFFSET);

   // Address decode on the captured address phase
   assign selAcc    = (dpAddr == ACC_OFFSET);
   assign selStatus = (dpAddr == STATUS_OFFSET);
   assign selCmd    = (dpAddr == CMD_OFFSET);
   assign selMem    = (dpAddr[7:6] == MEM_BASE[7:6]);

   // Plain register writes finish in their first data-phase cycle
   assign busWrite  = dpValid & dpWrite & dpSizeOk & (busState == BUS_IDLE);
   assign startCmd  = (busState == BUS_CMD) & (engState == ENG_IDLE) & ~engCommit;
   assign engCommit = (engState == ENG_EXEC);

   // Capture of the address phase until its data phase completes
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         dpValid  <= 1'b0;
         dpWrite  <= 1'b0;
         dpSizeOk <= 1'b0;
         dpAddr   <= 8'h00;
      end else if (accept) begin
         dpValid  <= 1'b1;
         dpWrite  <= hwrite;
         dpSizeOk <= (hsize == HSIZE_WORD);
         dpAddr   <= haddr[7:0];
      end else if (engCommit) begin
         dpValid  <= 1'b0;                                   // Command done, no stray write
      end else if (hreadyout) begin
         dpValid  <= 1'b0;
      end
   end

   // Bus sequencing: reads take two wait states, commands wait for the engine.
   // A command costs three: data capture, memory fetch, then execute and commit.
   // Stalling the bus is cheaper than a busy bit and keeps software simple,
   // at the price of a blocked bus while an operation is in flight.
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         busState  <= BUS_IDLE;
         hreadyout <= 1'b1;
      end else begin
         unique case (busState)
            BUS_IDLE: begin
               if (takeRead) begin
                  busState  <= BUS_READ1;
                  hreadyout <= 1'b0;
               end else if (takeCmd) begin
                  // Holding the bus keeps any other access off the memory port
                  busState  <= BUS_CMD;
                  hreadyout <= 1'b0;
               end
            end
            BUS_READ1: begin
               busState <= BUS_READ2;
            end
            BUS_READ2: begin
               busState  <= BUS_IDLE;
               hreadyout <= 1'b1;
            end
            BUS_CMD: begin
               if (engCommit) begin
                  busState  <= BUS_IDLE;
                  hreadyout <= 1'b1;
               end
            end
         endcase
      end
   end

   // Response is always OKAY, held in a flop so the output is registered
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         hresp <= HRESP_OKAY;
      end else begin
         hresp <= HRESP_OKAY;
      end
   end

   // Command capture from the write data
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         cmdOp    <= OP_ROTATE_RIGHT_TO_ACCUMULATOR;
         cmdIndex <= INDEX_RESET;
      end else if (startCmd) begin
         cmdOp    <= alu_op_t'(hwdata[CMD_OP_LSB +: CMD_OP_WIDTH]);
         cmdIndex <= hwdata[CMD_INDEX_LSB +: MEM_INDEX_WIDTH];
      end
   end

   // Engine: fetch the byte, then execute and commit in one cycle.
   // The memory read is registered, so the operand is only valid in the
   // execute cycle; committing earlier would use the previous byte.
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         engState <= ENG_IDLE;
      end else begin
         unique case (engState)
            ENG_IDLE: begin
               if (startCmd) begin
                  engState <= ENG_FETCH;
               end
            end
            ENG_FETCH: begin
               engState <= ENG_EXEC;
            end
            ENG_EXEC: begin
               engState <= ENG_IDLE;
            end
            default: begin
               engState <= ENG_IDLE;
            end
         endcase
      end
   end

   // Accumulator: software write or engine result
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         acc <= ACC_RESET;
      end else if (engCommit && aluToAcc) begin
         acc <= aluResult;
      end else if (busWrite && selAcc) begin
         acc <= hwdata[7:0];
      end
   end

   // Flags: only the bits the operation owns change.
   // Engine wins over software; the bus is stalled then, so no clash occurs.
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         flags <= FLAGS_RESET;
      end else if (engCommit) begin
         flags <= (flags & ~aluMask) | (aluFlags & aluMask);
      end else if (busWrite && selStatus) begin
         flags <= hwdata[FLAG_COUNT-1:0];
      end
   end

   // Memory ports; the read side follows the engine while it runs.
   // Memory bytes are not reset: software must write a byte before using it.
   assign memWe     = (engCommit & aluToMem) | (busWrite & selMem);

   // Port steering; the engine owns the read port while it runs and the write port when it commits
   always_comb begin
      memWIndex = dpAddr[MEM_INDEX_WIDTH+1:2];
      memWData  = hwdata[7:0];
      memRIndex = dpAddr[MEM_INDEX_WIDTH+1:2];
      if (engCommit) begin
         memWIndex = cmdIndex;
         memWData  = aluResult;
      end
      if (engState != ENG_IDLE) begin
         memRIndex = cmdIndex;
      end
   end

   data_byte_store #(
      .WIDTH (BYTE_WIDTH),
      .DEPTH (MEM_DEPTH),
      .AW    (MEM_INDEX_WIDTH)
   ) u_store (
      .clk         (sys_clk),
      .writeEnable (memWe),
      .writeIndex  (memWIndex),
      .writeData   (memWData),
      .readIndex   (memRIndex),
      .readData    (memRData)
   );

   alu_rotate_subtract u_alu (
      .op        (cmdOp),
      .accIn     (acc),
      .memIn     (memRData),
      .flagsIn   (flags),
      .result    (aluResult),
      .toAcc     (aluToAcc),
      .toMem     (aluToMem),
      .nextFlags (aluFlags),
      .flagMask  (aluMask)
   );

   // Read mux; unmapped offsets read as zero
   always_comb begin
      readWord = 32'h0000_0000;
      if (selAcc) begin
         readWord[7:0] = acc;
      end else if (selStatus) begin
         readWord[FLAG_COUNT-1:0] = flags;
      end else if (selCmd) begin
         readWord[CMD_OP_LSB +: CMD_OP_WIDTH]       = cmdOp;
         readWord[CMD_INDEX_LSB +: MEM_INDEX_WIDTH] = cmdIndex;
      end else if (selMem) begin
         readWord[7:0] = memRData;
      end
   end

   // Read data registered on the same edge that raises ready
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         hrdata <= 32'h0000_0000;
      end else if (busState == BUS_READ2) begin
         hrdata <= readWord;
      end
   end

endmodule // rotate_right_and_subtract_carry
`default_nettype wire

// ==== src/rr_sbc_pkg.sv ====
// Shared constants, field layout and operation codes of the rotate/subtract datapath
package rr_sbc_pkg;

   // Register byte offsets on the bus
   localparam logic [7:0] ACC_OFFSET    = 8'h00;
   localparam logic [7:0] STATUS_OFFSET = 8'h04;
   localparam logic [7:0] CMD_OFFSET    = 8'h08;
   localparam logic [7:0] MEM_BASE      = 8'h40;

   // Data memory geometry: one byte per aligned word
   localparam int         MEM_DEPTH       = 16;
   localparam int         MEM_INDEX_WIDTH = 4;
   localparam int         BYTE_WIDTH      = 8;

   // Flag bit positions in the status register
   localparam int         FLAG_C     = 0;
   localparam int         FLAG_AC    = 1;
   localparam int         FLAG_Z     = 2;
   localparam int         FLAG_OV    = 3;
   localparam int         FLAG_SC    = 4;
   localparam int         FLAG_CZ    = 5;
   localparam int         FLAG_COUNT = 6;

   // Command register fields
   localparam int         CMD_OP_LSB    = 0;
   localparam int         CMD_OP_WIDTH  = 2;
   localparam int         CMD_INDEX_LSB = 8;

   // Reset values
   localparam logic [7:0] ACC_RESET   = 8'h00;
   localparam logic [5:0] FLAGS_RESET = 6'h00;
   localparam logic [3:0] INDEX_RESET = 4'h0;

   // Bus encodings
   localparam logic [2:0] HSIZE_WORD = 3'h2;
   localparam logic       HRESP_OKAY = 1'h0;

   // Datapath operations
   typedef enum logic [1:0] {
      OP_ROTATE_RIGHT_TO_ACCUMULATOR       = 2'b00,
      OP_ROTATE_RIGHT_CARRY_IN_PLACE       = 2'b01,
      OP_ROTATE_RIGHT_CARRY_TO_ACCUMULATOR = 2'b10,
      OP_SUBTRACT_WITH_BORROW              = 2'b11
   } alu_op_t;

endpackage

// ==== test/rotate_right_and_subtract_carry_tb.sv ====
// Self-checking bench of the rotate/subtract block over its register bus
`timescale 1ns/1ps
`default_nettype none
module rotate_right_and_subtract_carry_tb
   import rr_sbc_pkg::*;
;
   // Clock, reset and bus
   logic        sys_clk;
   logic        rst_n;
   logic        hsel;
   logic        hwrite;
   logic [1:0]  htrans;
   logic [2:0]  hsize;
   logic [31:0] haddr;
   logic [31:0] hwdata;
   wire  logic [31:0] hrdata;
   wire  logic  hreadyout;
   wire  logic  hresp;
   // Scoreboard
   int          errorCnt = 0;
   int          totalChecks = 0;
   logic [31:0] rdData;
   logic [31:0] accW;
   logic [31:0] flW;
   logic [31:0] memW;

   rotate_right_and_subtract_carry rotate_right_and_subtract_carry_i (
      .sys_clk(sys_clk), .rst_n(rst_n), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
      .hsize(hsize), .hready(hreadyout), .hwdata(hwdata), .hrdata(hrdata), .hreadyout(hreadyout),
      .hresp(hresp));

   // 200 MHz clock
   initial begin
      sys_clk = 1'b0;
      forever #2.5 sys_clk = ~sys_clk;
   end

   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      totalChecks++;
      if (seen !== exp) begin
         errorCnt++;
         $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask

   // Ready is read mid-cycle, where the registered output has settled
   task automatic wait_ready();
      int n;
      logic r;
      n = 0;
      do begin
         @(negedge sys_clk);
         r = hreadyout;
         rdData = hrdata;
         @(posedge sys_clk);
         n++;
      end while (r !== 1'b1 && n < 50);
      if (r !== 1'b1) errorCnt++;
   endtask

   task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [2:0] sz);
      hsel <= 1'b1;
      haddr <= {24'h0, a};
      htrans <= 2'b10;
      hwrite <= w;
      hsize <= sz;
      wait_ready();
      htrans <= 2'b00;
      hsel <= 1'b0;
      hwdata <= d;
      wait_ready();
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      bus(1'b1, a, d, HSIZE_WORD);
   endtask

   task automatic rd(input logic [7:0] a);
      bus(1'b0, a, 32'h0, HSIZE_WORD);
   endtask

   // Load operands, start one operation, read all three places back
   task automatic run_op(input alu_op_t op, input logic [3:0] i, input logic [7:0] a, m, input logic [5:0] f);
      wr(ACC_OFFSET, {24'h0, a});
      wr(STATUS_OFFSET, {26'h0, f});
      wr(MEM_BASE + {i, 2'b00}, {24'h0, m});
      wr(CMD_OFFSET, {20'h0, i, 6'h00, op});
      rd(ACC_OFFSET);
      accW = rdData;
      rd(STATUS_OFFSET);
      flW = rdData;
      rd(MEM_BASE + {i, 2'b00});
      memW = rdData;
   endtask

   // Expected {flags, difference} of a subtract with borrow
   function automatic logic [13:0] sub_model(input logic [7:0] a, m, input logic [5:0] f);
      logic [8:0] d;
      logic [4:0] nib;
      logic [5:0] nf;
      d = {1'b0, a} - {1'b0, m} - {8'h0, ~f[FLAG_C]};
      nib = {1'b0, a[3:0]} - {1'b0, m[3:0]} - {4'h0, ~f[FLAG_C]};
      nf[FLAG_C] = ~d[8];
      nf[FLAG_AC] = ~nib[4];
      nf[FLAG_Z] = d[7:0] == 8'h00;
      nf[FLAG_OV] = (a[7] ^ m[7]) & (d[7] ^ a[7]);
      nf[FLAG_SC] = nf[FLAG_OV] ^ d[7];
      nf[FLAG_CZ] = nf[FLAG_Z] & f[FLAG_CZ];
      return {nf, d[7:0]};
   endfunction

   task automatic test_reset();
      rd(ACC_OFFSET);
      check(rdData, 32'h0);
      rd(STATUS_OFFSET);
      check(rdData, 32'h0);
   endtask

   task automatic test_rotate_acc();
      run_op(OP_ROTATE_RIGHT_TO_ACCUMULATOR, 4'hf, 8'h00, 8'h81, 6'h2a);
      check(accW, 32'hc0);
      check(flW, 32'h2a);
      check(memW, 32'h81);
      run_op(OP_ROTATE_RIGHT_TO_ACCUMULATOR, 4'h0, 8'hff, 8'h02, 6'h15);
      check(accW, 32'h01);
   endtask

   task automatic test_carry_mem();
      run_op(OP_ROTATE_RIGHT_CARRY_IN_PLACE, 4'h7, 8'h5a, 8'h02, 6'h3f);
      check(memW, 32'h81);
      check(flW, 32'h3e);
      check(accW, 32'h5a);
      run_op(OP_ROTATE_RIGHT_CARRY_IN_PLACE, 4'h8, 8'h5a, 8'h01, 6'h00);
      check(memW, 32'h00);
      check(flW, 32'h01);
   endtask

   task automatic test_carry_acc();
      run_op(OP_ROTATE_RIGHT_CARRY_TO_ACCUMULATOR, 4'h1, 8'h00, 8'h55, 6'h1f);
      check(accW, 32'haa);
      check(flW, 32'h1f);
      check(memW, 32'h55);
      run_op(OP_ROTATE_RIGHT_CARRY_TO_ACCUMULATOR, 4'h2, 8'h00, 8'haa, 6'h20);
      check(accW, 32'h55);
      check(flW, 32'h20);
   endtask

   // Positive, negative, zero with chain, and both overflow directions
   task automatic test_subtract();
      logic [7:0] sa [5] = '{8'h50, 8'h00, 8'h10, 8'h80, 8'h7f};
      logic [7:0] sm [5] = '{8'h20, 8'h01, 8'h0f, 8'h01, 8'h80};
      logic [5:0] sf [5] = '{6'h01, 6'h01, 6'h20, 6'h01, 6'h00};
      logic [13:0] e;
      for (int i = 0; i < 5; i++) begin
         e = sub_model(sa[i], sm[i], sf[i]);
         run_op(OP_SUBTRACT_WITH_BORROW, 4'(i * 3), sa[i], sm[i], sf[i]);
         check(accW, {24'h0, e[7:0]});
         check({31'h0, flW[FLAG_C]}, {31'h0, e[8 + FLAG_C]});
         check(flW, {26'h0, e[13:8]});
         check(memW, {24'h0, sm[i]});
      end
   endtask

   // Byte-sized command is ignored; unmapped place reads zero
   task automatic test_bus_misc();
      wr(ACC_OFFSET, 32'hffff_ff33);
      bus(1'b1, CMD_OFFSET, 32'h0, 3'h0);
      rd(ACC_OFFSET);
      check(rdData, 32'h33);
      rd(CMD_OFFSET);
      check(rdData, 32'h0000_0c03);
      wr(8'h34, 32'h77);
      rd(8'h34);
      check(rdData, 32'h0);
   endtask

   task automatic print_verdict();
      $display("checks %0d mismatches %0d", totalChecks, errorCnt);
      if (errorCnt == 0 && totalChecks > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask

   // Main sequence
   initial begin
      rst_n = 1'b0;
      hsel = 1'b0;
      hwrite = 1'b0;
      htrans = 2'b00;
      hsize = HSIZE_WORD;
      haddr = 32'h0;
      hwdata = 32'h0;
      repeat (20) @(posedge sys_clk);
      rst_n <= 1'b1;
      @(posedge sys_clk);
      test_reset();
      test_rotate_acc();
      test_carry_mem();
      test_carry_acc();
      test_subtract();
      test_bus_misc();
      print_verdict();
   end

   // Watchdog: the run needs well under two thousand cycles
   initial begin
      repeat (20000) @(posedge sys_clk);
      errorCnt++;
      print_verdict();
   end
endmodule // rotate_right_and_subtract_carry_tb
`default_nettype wire

// ==== test/rr_sbc_properties.sv ====
// Bus timing and read-back properties of the rotate/subtract block
`timescale 1ns/1ps
`default_nettype none
module rr_sbc_properties
   import rr_sbc_pkg::*;
(
   // Clock and reset
   input wire logic        sys_clk,
   input wire logic        rst_n,
   // Bus requests
   input wire logic        hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0]  htrans,
   input wire logic        hwrite,
   input wire logic [2:0]  hsize,
   input wire logic        hready,
   // Bus answers
   input wire logic [31:0] hrdata,
   input wire logic        hreadyout,
   input wire logic        hresp
);
   default clocking @(posedge sys_clk); endclocking
   default disable iff (!rst_n);

   // Accepted address phases by kind
   wire logic take = hsel && htrans[1] && hready;
   wire logic rd   = take && !hwrite;
   wire logic cmd  = take && hwrite && haddr[7:0] == CMD_OFFSET && hsize == HSIZE_WORD;

   read_wait_a: assert property (rd |=> !hreadyout [*2] ##1 hreadyout)
      else $error("read wait count wrong");
   cmd_wait_a: assert property (cmd |=> !hreadyout [*3] ##1 hreadyout)
      else $error("command wait count wrong");
   write_fast_a: assert property (take && hwrite && !cmd |=> hreadyout)
      else $error("plain write stalled");
   resp_okay_a: assert property (hresp == HRESP_OKAY)
      else $error("response not okay");
   read_upper_a: assert property (rd && haddr[7:0] != CMD_OFFSET |=> ##2 hrdata[31:8] == 24'h0)
      else $error("upper read bits set");
   status_bits_a: assert property (rd && haddr[7:0] == STATUS_OFFSET |=> ##2 hrdata[31:6] == 26'h0)
      else $error("status reserved bits set");
   data_hold_a: assert property (!$rose(hreadyout) |-> $stable(hrdata))
      else $error("read data moved");
   wait_cause_a: assert property ($fell(hreadyout) |-> $past(take))
      else $error("stall without request");

   // Main scenarios reached
   cover property (cmd);
   cover property (rd ##3 hreadyout);
   cover property (take && hwrite && hsize != HSIZE_WORD);
endmodule // rr_sbc_properties

bind rotate_right_and_subtract_carry rr_sbc_properties rr_sbc_properties_i (
   .sys_clk(sys_clk), .rst_n(rst_n), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
   .hsize(hsize), .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp));
`default_nettype wire
